/* File: src/spipp_defines.svh */
`ifndef SPIPP_DEFINES_SVH
`define SPIPP_DEFINES_SVH
// ----------------------------------------
// field positions
// ----------------------------------------
`define SPIPP_CTRL_SEL_BIT   0
`define SPIPP_PHASE_BIT      16
`define SPIPP_POL_BIT        17
`define SPIPP_PS_LSB         8
`define SPIPP_PS_MSB         15
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SPIPP_CTRL_RST       32'h00000000
`define SPIPP_FMT_RST        32'h00000000
`define SPIPP_WORD_BITS      16
`define SPIPP_MIN_PERIOD_NS  25
`define SPIPP_CLK_PERIOD_NS  100
`define SPIPP_MIN_PERIOD_CYC ((`SPIPP_MIN_PERIOD_NS + `SPIPP_CLK_PERIOD_NS - 1) / `SPIPP_CLK_PERIOD_NS)
`define SPIPP_SEL_WAIT_SCLK  2
`endif

/* File: src/spipp_pkg.sv */
package spipp_pkg;
	typedef enum logic [1:0] {
		SPIPP_IDLE,
		SPIPP_SETTLE,
		SPIPP_SHIFT,
		SPIPP_DONE
	} spipp_state_e;

	typedef struct packed {
		logic        phase;
		logic        polarity;
		logic [7:0]  prescale;
	} spipp_fmt_s;

	typedef struct packed {
		logic        sclk;
		logic        sel_n;
		logic        mosi;
	} spipp_pins_s;
endpackage : spipp_pkg

/* File: src/spipp_edge.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// edge detector on a sampled pin
// ----------------------------------------
module spipp_edge (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output var  logic rise,
	output var  logic fall,
	output var  logic level
);
	logic prev_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// start from the pin level, so no false edge follows reset
			prev_reg <= pin;
		end else begin
			prev_reg <= pin;
		end
	end

	always_comb begin
		rise  = pin & ~prev_reg;
		fall  = ~pin & prev_reg;
		level = prev_reg;
	end
endmodule : spipp_edge
`default_nettype wire

/* File: src/spipp_port.sv */
// How it works
// R1 - control bit 0 clear selects peripheral
// R2 - clock and host data in, device data out
// R3 - format bit 16 selects clock phase
// R4 - format bit 17 selects active edge
// R5 - prescale bits 15:8 bound serial clock period
// R6 - launch output after rising edge, polarity dependent
// R7 - host waits two clocks after select
// R8 - host reframes select every 16 bits
// R9 - sample on edge opposite the launch
`timescale 1ns/1ps
`default_nettype none
`include "spipp_defines.svh"
module spipp_port
	import spipp_pkg::*;
#(
	parameter int WORD_BITS = `SPIPP_WORD_BITS
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic [31:0]          global_control_reg,
	input  wire logic [31:0]          format_reg,
	input  wire logic                 serial_clock_pin,
	input  wire logic                 chip_select_n,
	input  wire logic                 host_to_device_data,
	input  wire logic [WORD_BITS-1:0] tx_word,
	output logic                      device_to_host_data,
	output logic                      device_to_host_oe_n,
	output logic [WORD_BITS-1:0]      rx_word,
	output logic                      rx_valid,
	output logic                      tx_load,
	output logic                      period_error,
	output logic                      peripheral_mode
);
	localparam int CNT_W = $clog2(WORD_BITS + 1);
	// floor on the serial period in whole clock cycles
	localparam logic [8:0] FLOOR_CYC = 9'(`SPIPP_MIN_PERIOD_CYC);

	spipp_fmt_s             fmt;
	spipp_pins_s            pins;
	logic                   is_periph;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic                   launch_edge;
	logic                   sample_edge;
	logic                   sel_fall;
	logic                   active;
	logic                   last_bit;
	logic [WORD_BITS-1:0]   tx_sh_reg;
	logic [WORD_BITS-1:0]   rx_sh_reg;
	logic [CNT_W-1:0]       bit_cnt_reg;
	logic [8:0]             per_cnt_reg;
	logic [8:0]             ps_cycles;
	logic [8:0]             min_cycles;
	logic                   first_launch_reg;

	// ----------------------------------------
	// configuration decode
	// ----------------------------------------
	always_comb begin
		fmt.phase    = format_reg[`SPIPP_PHASE_BIT]; // R3
		fmt.polarity = format_reg[`SPIPP_POL_BIT]; // R4
		fmt.prescale = format_reg[`SPIPP_PS_MSB:`SPIPP_PS_LSB]; // R5
		is_periph    = ~global_control_reg[`SPIPP_CTRL_SEL_BIT]; // R1
		pins.sclk    = serial_clock_pin; // R2
		pins.sel_n   = chip_select_n;
		pins.mosi    = host_to_device_data;
	end

	spipp_edge u_sclk_edge (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin     (pins.sclk),
		.rise    (sclk_rise),
		.fall    (sclk_fall),
		.level   ()
	);

	spipp_edge u_sel_edge (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin     (pins.sel_n),
		.rise    (),
		.fall    (sel_fall),
		.level   ()
	);

	// ----------------------------------------
	// edge selection
	// ----------------------------------------
	always_comb begin
		launch_edge = fmt.polarity ? sclk_fall : sclk_rise; // R6
		sample_edge = fmt.polarity ? sclk_rise : sclk_fall; // R9
		active      = is_periph & ~pins.sel_n;
		last_bit    = (bit_cnt_reg == CNT_W'(WORD_BITS - 1));
		ps_cycles   = (fmt.prescale == 8'h00) ? 9'h002 : ({1'b0, fmt.prescale} + 9'h001); // R5
		min_cycles  = (ps_cycles < FLOOR_CYC) ? FLOOR_CYC : ps_cycles; // R5
	end

	// ----------------------------------------
	// transmit shifter
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_sh_reg        <= '0;
			first_launch_reg <= 1'b0;
		end else begin
			if (active && sel_fall) begin
				// phase 1 launches first bit on first edge
				tx_sh_reg        <= tx_word;
				first_launch_reg <= fmt.phase; // R3
			end else if (active && launch_edge) begin
				if (first_launch_reg) begin
					first_launch_reg <= 1'b0;
				end else begin
					tx_sh_reg <= {tx_sh_reg[WORD_BITS-2:0], 1'b0}; // R6
				end
			end
		end
	end

	// ----------------------------------------
	// load strobe
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_load <= 1'b0;
		end else begin
			tx_load <= active & sel_fall;
		end
	end

	// ----------------------------------------
	// role flag
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			peripheral_mode <= 1'b1;
		end else begin
			peripheral_mode <= is_periph; // R1
		end
	end

	// ----------------------------------------
	// output enable
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			device_to_host_oe_n <= 1'b1;
		end else begin
			device_to_host_oe_n <= ~active; // R2
		end
	end

	// ----------------------------------------
	// output pin
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			device_to_host_data <= 1'b0;
		end else begin
			if (active && sel_fall) begin
				device_to_host_data <= tx_word[WORD_BITS-1];
			end else if (active && launch_edge && !first_launch_reg) begin
				device_to_host_data <= tx_sh_reg[WORD_BITS-2]; // R6
			end else if (active && launch_edge) begin
				device_to_host_data <= tx_sh_reg[WORD_BITS-1];
			end
		end
	end

	// ----------------------------------------
	// receive shifter
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_sh_reg   <= '0;
			bit_cnt_reg <= '0;
			rx_word     <= '0;
		end else begin
			if (!active || sel_fall) begin
				bit_cnt_reg <= '0; // R8
			end else if (sample_edge) begin
				rx_sh_reg <= {rx_sh_reg[WORD_BITS-2:0], pins.mosi}; // R9
				if (last_bit) begin
					rx_word     <= {rx_sh_reg[WORD_BITS-2:0], pins.mosi};
					bit_cnt_reg <= '0; // R8
				end else begin
					bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
				end
			end
		end
	end

	// ----------------------------------------
	// word strobe
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= active & ~sel_fall & sample_edge & last_bit; // R9
		end
	end

	// ----------------------------------------
	// serial clock period check
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			per_cnt_reg  <= '0;
			period_error <= 1'b0;
		end else begin
			// a new frame clears the flag, a short period in the same cycle wins
			if (sel_fall) begin
				period_error <= 1'b0;
			end
			if (!active) begin
				per_cnt_reg <= '0;
			end else if (sclk_rise) begin
				// half periods measured together as one full period
				if (per_cnt_reg != 9'h000 && per_cnt_reg < (min_cycles - 9'h001)) begin
					period_error <= 1'b1; // R5
				end
				per_cnt_reg <= '0;
			end else if (per_cnt_reg != 9'h1FF) begin
				per_cnt_reg <= per_cnt_reg + 9'h001;
			end
		end
	end
endmodule : spipp_port
`default_nettype wire

/* File: verif/spipp_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module spipp_port_props #(parameter int WORD_BITS = 16) (
	input wire logic                 ref_clk,
	input wire logic                 sys_rst,
	input wire logic [31:0]          global_control_reg,
	input wire logic [31:0]          format_reg,
	input wire logic                 serial_clock_pin,
	input wire logic                 chip_select_n,
	input wire logic [WORD_BITS-1:0] tx_word,
	input wire logic                 device_to_host_data,
	input wire logic                 device_to_host_oe_n,
	input wire logic                 rx_valid,
	input wire logic                 tx_load,
	input wire logic                 peripheral_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_off; (chip_select_n || global_control_reg[0])[*3]; endsequence
	sequence s_ctl; global_control_reg[0][*3]; endsequence
	property p_mode; 1 |=> peripheral_mode == !$past(global_control_reg[0]); endproperty
	a_mode: assert property (p_mode) else $error("mode bit");
	property p_quiet; s_ctl |-> !rx_valid && !tx_load; endproperty
	a_quiet: assert property (p_quiet) else $error("shift in controller mode");
	property p_oe; s_off |-> device_to_host_oe_n; endproperty
	a_oe: assert property (p_oe) else $error("driving when off");
	property p_load; $fell(chip_select_n) && peripheral_mode |-> ##[1:3] tx_load; endproperty
	a_load: assert property (p_load) else $error("no load");
	property p_first;
		tx_load |-> !device_to_host_oe_n && device_to_host_data == tx_word[WORD_BITS-1];
	endproperty
	a_first: assert property (p_first) else $error("first bit");
	property p_pol0; !format_reg[17] && $fell(serial_clock_pin) |-> $stable(device_to_host_data)[*3];
	endproperty
	a_pol0: assert property (p_pol0) else $error("launch edge");
	property p_pol1; format_reg[17] && $rose(serial_clock_pin) |-> $stable(device_to_host_data)[*3];
	endproperty
	a_pol1: assert property (p_pol1) else $error("launch edge");
	property p_rx; rx_valid |-> !device_to_host_oe_n ##1 !rx_valid; endproperty
	a_rx: assert property (p_rx) else $error("word pulse");
endmodule : spipp_port_props
`default_nettype wire

/* File: verif/spipp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// host controller model
// ----
module spipp_host import spipp_pkg::*; #(parameter int HALF = 4) (
	input  wire logic ref_clk,
	input  wire logic device_to_host_data,
	output var  logic serial_clock_pin,
	output var  logic chip_select_n,
	output var  logic host_to_device_data
);
	initial begin
		serial_clock_pin = 1'b0;
		chip_select_n = 1'b1;
		host_to_device_data = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input spipp_fmt_s f, output logic [15:0] r);
		int b;
		b = 0;
		r = 16'h0;
		repeat (2 * HALF) @(posedge ref_clk);
		serial_clock_pin <= ~(f.polarity ^ f.phase);
		host_to_device_data <= w[15];
		repeat (2 * HALF) @(posedge ref_clk);
		chip_select_n <= 1'b0;
		repeat (4 * HALF) @(posedge ref_clk);
		for (int k = 0; k < 32; k++) begin
			repeat (HALF) @(posedge ref_clk);
			serial_clock_pin <= ~serial_clock_pin;
			if (k[0] == f.phase) begin
				r = {r[14:0], device_to_host_data};
				b++;
			end else begin
				host_to_device_data <= (b < 16) ? w[15 - b] : ~host_to_device_data;
			end
		end
		repeat (HALF) @(posedge ref_clk);
		chip_select_n <= 1'b1;
		host_to_device_data <= ~host_to_device_data;
	endtask : xfer
endmodule : spipp_host
`default_nettype wire

/* File: verif/spi_peripheral_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module spi_peripheral_port_test import spipp_pkg::*; ;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [31:0] global_control_reg = 32'h0;
	logic [31:0] format_reg = 32'h0;
	logic [15:0] tx_word = 16'h0;
	logic [15:0] rx_word;
	logic        serial_clock_pin, chip_select_n, host_to_device_data, device_to_host_data;
	logic        device_to_host_oe_n, rx_valid, tx_load, period_error, peripheral_mode;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic        miso_line;
	// a released line shows the inverse of the held value
	assign miso_line = device_to_host_oe_n ? ~device_to_host_data : device_to_host_data;
	always #50 ref_clk = ~ref_clk;
	spipp_port uut (.ref_clk, .sys_rst, .global_control_reg, .format_reg, .serial_clock_pin,
		.chip_select_n, .host_to_device_data, .tx_word, .device_to_host_data,
		.device_to_host_oe_n, .rx_word, .rx_valid, .tx_load, .period_error, .peripheral_mode);
	spipp_host u_host (.ref_clk, .device_to_host_data(miso_line), .serial_clock_pin,
		.chip_select_n, .host_to_device_data);
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic frame(input logic [15:0] t, input logic [15:0] h, input spipp_fmt_s f);
		logic [15:0] r;
		tx_word <= t;
		format_reg <= {14'h0, f.polarity, f.phase, f.prescale, 8'h00};
		u_host.xfer(h, f, r);
		chk(rx_word, h);
		chk(r, t);
	endtask : frame
	task automatic test_modes();
		for (int m = 0; m < 4; m++) begin
			frame(16'h8001 ^ 16'(m), 16'h7FFE ^ 16'(m), '{m[0], m[1], 8'h07});
			chk({15'h0, period_error}, 16'h0);
		end
	endtask : test_modes
	task automatic test_rate();
		frame(16'hFFFF, 16'h0000, '{1'b0, 1'b0, 8'h08});
		chk({15'h0, period_error}, 16'h1);
		frame(16'h0001, 16'h8000, '{1'b1, 1'b1, 8'h00});
		chk({15'h0, period_error}, 16'h0);
	endtask : test_rate
	task automatic test_ctrl();
		logic [15:0] r;
		global_control_reg <= 32'h1;
		u_host.xfer(16'h1234, '{1'b0, 1'b0, 8'h07}, r);
		chk({14'h0, peripheral_mode, device_to_host_oe_n}, 16'h1);
		chk(rx_word, 16'h8000);
		chk(r, 16'h0000);
		global_control_reg <= 32'h0;
	endtask : test_ctrl
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		test_modes();
		test_rate();
		test_ctrl();
		stop_test();
	end
endmodule : spi_peripheral_port_test
bind spipp_port spipp_port_props #(.WORD_BITS(WORD_BITS)) u_props (.ref_clk, .sys_rst,
	.global_control_reg, .format_reg, .serial_clock_pin, .chip_select_n, .tx_word,
	.device_to_host_data, .device_to_host_oe_n, .rx_valid, .tx_load, .peripheral_mode);
`default_nettype wire
